// *** hdl/lsi_flag.sv ***
`timescale 1ns/1ps
`default_nettype none
// sticky flag: set wins over clear
module lsi_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (set_in) begin
      flag_next = 1'b1;
    end else if (clr_in) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;
endmodule
`default_nettype wire

// *** hdl/lsi_idstat.sv ***
`timescale 1ns/1ps
`default_nettype none
// identifier decode: status code and checksum model
module lsi_idstat (
  input  wire logic [5:0] ident_in,
  output logic [2:0]      ident_status_code,
  output logic            classic_only
);
  always_comb begin
    if (ident_in >= lsi_pkg::ID_RSV_BASE) begin
      ident_status_code = {1'b1, 2'(ident_in - lsi_pkg::ID_RSV_BASE)};
    end else begin
      ident_status_code = 3'h0;
    end
    classic_only = (ident_in == lsi_pkg::ID_DIAG_LO)
                 || (ident_in == lsi_pkg::ID_DIAG_HI);
  end
endmodule
`default_nettype wire

// *** hdl/lsi_pkg.sv ***
`default_nettype none
package lsi_pkg;
  // register byte addresses on apb (0xc9/0xca are not word multiples: index*4)
  localparam logic [7:0]  STATUS_IDX   = 8'hC9;
  localparam logic [7:0]  BITTIME_IDX  = 8'hCC;
  localparam logic [7:0]  IRQEN_IDX    = 8'hCA;
  localparam logic [7:0]  ERRFLAG_IDX  = 8'hCB;
  localparam logic [7:0]  DATA_IDX     = 8'hD2;
  localparam logic [7:0]  CTRL_IDX     = 8'hC8;
  localparam logic [11:0] STATUS_ADDR  = 12'h324;
  localparam logic [11:0] BITTIME_ADDR = 12'h330;
  localparam logic [11:0] IRQEN_ADDR   = 12'h328;
  localparam logic [11:0] ERRFLAG_ADDR = 12'h32C;
  localparam logic [11:0] DATA_ADDR    = 12'h348;
  localparam logic [11:0] CTRL_ADDR    = 12'h320;
  // reset values
  localparam logic [7:0]  STATUS_RST   = 8'h00;
  localparam logic [7:0]  IRQEN_RST    = 8'h00;
  localparam logic [7:0]  ERRFLAG_RST  = 8'h00;
  localparam logic [5:0]  BITTIME_RST  = 6'h20;
  // status field positions, and resync bit of bit timing register
  localparam int          ERR_BIT      = 3;
  localparam int          ID_BIT       = 2;
  localparam int          TX_BIT       = 1;
  localparam int          RX_BIT       = 0;
  localparam int          RESYNC_BIT   = 7;
  // reserved diagnostic identifiers
  localparam logic [5:0]  ID_DIAG_LO   = 6'h3C;
  localparam logic [5:0]  ID_DIAG_HI   = 6'h3D;
  localparam logic [5:0]  ID_RSV_BASE  = 6'h3C;
endpackage
`default_nettype wire

// *** hdl/lsi_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsi_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_active,
  input  wire logic        tx_active,
  input  wire logic [5:0]  ident_in,
  input  wire logic        ident_rx_done,
  input  wire logic        header_tx_done,
  input  wire logic        tx_resp_done,
  input  wire logic        rx_resp_done,
  input  wire logic [7:0]  err_event,
  input  wire logic [7:0]  rx_data_in,
  output logic [7:0]       tx_data_out,
  output logic             tx_data_load,
  output logic             uart_mode,
  output logic             classic_only,
  output logic             resync_enable,
  output logic [5:0]       bit_timing_field,
  output logic             irq_comm,
  output logic             irq_error
);
  logic [7:0] irq_en_reg;
  logic [7:0] irq_en_next;
  logic [7:0] err_reg;
  logic [7:0] err_next;
  logic [6:0] btr_reg;
  logic [6:0] btr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic       ctrl_reg;
  logic       ctrl_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic       pslverr_next;
  logic       load_reg;
  logic       load_next;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit;
  logic       wr_status;
  logic       clr_err;
  logic       clr_id;
  logic       clr_tx;
  logic       clr_rx;
  logic       data_rd;
  logic       data_wr;
  logic       ident_done_flag;
  logic       tx_response_done_flag;
  logic       rx_response_done_flag;
  logic       summary_error_flag;
  logic       bus_activity_flag;
  logic [2:0] ident_status_code;
  logic [7:0] status_val;
  logic       en_wr;

  assign wr_acc    = psel && penable && pwrite;
  assign rd_acc    = psel && penable && !pwrite;
  assign pready    = 1'b1;
  assign wr_status = wr_acc && (paddr == lsi_pkg::STATUS_ADDR);
  assign data_rd   = rd_acc && (paddr == lsi_pkg::DATA_ADDR);
  assign data_wr   = wr_acc && (paddr == lsi_pkg::DATA_ADDR);
  assign en_wr     = wr_acc && (paddr == lsi_pkg::IRQEN_ADDR);

  // write-one-to-clear strobes; uart data access clears too
  assign clr_err = (wr_status && pwdata[lsi_pkg::ERR_BIT]) || (ctrl_reg && data_rd);
  assign clr_id  = wr_status && pwdata[lsi_pkg::ID_BIT];
  assign clr_tx  = (wr_status && pwdata[lsi_pkg::TX_BIT]) || (ctrl_reg && data_wr);
  assign clr_rx  = (wr_status && pwdata[lsi_pkg::RX_BIT]) || (ctrl_reg && data_rd);

  lsi_flag u_id (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_in   (ident_rx_done || header_tx_done),
    .clr_in   (clr_id),
    .flag_out (ident_done_flag)
  );
  lsi_flag u_tx (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_in   (tx_resp_done),
    .clr_in   (clr_tx),
    .flag_out (tx_response_done_flag)
  );
  lsi_flag u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_in   (rx_resp_done),
    .clr_in   (clr_rx),
    .flag_out (rx_response_done_flag)
  );
  lsi_idstat u_ids (
    .ident_in          (ident_in),
    .ident_status_code (ident_status_code),
    .classic_only      (classic_only)
  );

  // error register: events set, summary clear wipes all but same-cycle events
  always_comb begin
    err_next = err_reg | err_event;
    if (clr_err) begin
      err_next = err_event;
    end
  end

  assign summary_error_flag = |err_reg;
  assign bus_activity_flag  = rx_active || tx_active;
  assign status_val = {ident_status_code, bus_activity_flag, summary_error_flag,
                       ident_done_flag, tx_response_done_flag, rx_response_done_flag};

  // register writes and read mux
  always_comb begin
    hit          = 1'b1;
    irq_en_next  = irq_en_reg;
    btr_next     = btr_reg;
    data_next    = data_reg;
    ctrl_next    = ctrl_reg;
    load_next    = 1'b0;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (paddr == lsi_pkg::STATUS_ADDR) begin
      prdata_next = {24'h000000, status_val};
    end else if (paddr == lsi_pkg::IRQEN_ADDR) begin
      prdata_next = {24'h000000, irq_en_reg};
      if (wr_acc) begin
        irq_en_next = {4'h0, pwdata[3:0]};
      end
    end else if (paddr == lsi_pkg::ERRFLAG_ADDR) begin
      prdata_next = {24'h000000, err_reg};
    end else if (paddr == lsi_pkg::BITTIME_ADDR) begin
      prdata_next = {24'h000000, btr_reg[6], 1'b0, btr_reg[5:0]};
      if (wr_acc) begin
        btr_next = {pwdata[lsi_pkg::RESYNC_BIT], pwdata[5:0]};
      end
    end else if (paddr == lsi_pkg::DATA_ADDR) begin
      prdata_next = {24'h000000, rx_data_in};
      if (wr_acc) begin
        data_next = pwdata[7:0];
        load_next = 1'b1;
      end
    end else if (paddr == lsi_pkg::CTRL_ADDR) begin
      prdata_next = {31'h00000000, ctrl_reg};
      if (wr_acc) begin
        ctrl_next = pwdata[0];
      end
    end else begin
      hit         = 1'b0;
      prdata_next = 32'h00000000;
    end
    if (!(psel && penable)) begin
      prdata_next = prdata_reg;
    end else if (!hit) begin
      pslverr_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg  <= lsi_pkg::IRQEN_RST;
      err_reg     <= lsi_pkg::ERRFLAG_RST;
      btr_reg     <= {1'b0, lsi_pkg::BITTIME_RST};
      data_reg    <= 8'h00;
      ctrl_reg    <= 1'b0;
      prdata_reg  <= 32'h00000000;
      load_reg    <= 1'b0;
    end else begin
      irq_en_reg  <= irq_en_next;
      err_reg     <= err_next;
      btr_reg     <= btr_next;
      data_reg    <= data_next;
      ctrl_reg    <= ctrl_next;
      prdata_reg  <= prdata_next;
      load_reg    <= load_next;
    end
  end

  // apb answers in the access cycle: read data combinational from regs
  always_comb begin
    if (rd_acc) begin
      prdata = prdata_next;
    end else begin
      prdata = prdata_reg;
    end
  end
  assign pslverr = pslverr_next;

  assign tx_data_out      = data_reg;
  assign tx_data_load     = load_reg;
  assign uart_mode        = ctrl_reg;
  assign resync_enable    = !btr_reg[6];
  assign bit_timing_field = btr_reg[5:0];
  assign irq_comm  = (ident_done_flag && irq_en_reg[lsi_pkg::ID_BIT])
                   || (tx_response_done_flag && irq_en_reg[lsi_pkg::TX_BIT])
                   || (rx_response_done_flag && irq_en_reg[lsi_pkg::RX_BIT]);
  assign irq_error = summary_error_flag && irq_en_reg[lsi_pkg::ERR_BIT];

  // checker steps
  sequence seq_err_hit;
    err_event != 8'h00;
  endsequence
  sequence seq_err_wipe;
    clr_err && (err_event == 8'h00);
  endsequence
  sequence seq_uart_rd;
    uart_mode && data_rd;
  endsequence
  sequence seq_uart_wr;
    uart_mode && data_wr;
  endsequence
  sequence seq_btr_write;
    wr_acc && (paddr == lsi_pkg::BITTIME_ADDR);
  endsequence

  // error register and summary flag
  AST_ERR_OR: assert property (@(posedge pclk) disable iff (!presetn)
    seq_err_hit |=> summary_error_flag)
    else $error("error summary not raised");
  AST_ERR_BITS: assert property (@(posedge pclk) disable iff (!presetn)
    seq_err_hit |=> ((err_reg & $past(err_event)) == $past(err_event)))
    else $error("error bit not set");
  AST_ERR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    seq_err_wipe |=> ((err_reg == 8'h00) && !summary_error_flag))
    else $error("errors not cleared");
  AST_ERR_UART: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_uart_rd ##0 (err_event == 8'h00)) |=> !summary_error_flag)
    else $error("uart read left error set");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_err_hit ##0 (irq_en_reg[lsi_pkg::ERR_BIT] && !en_wr)) |=> irq_error)
    else $error("error irq missing");
  AST_IRQ_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_en_reg[lsi_pkg::ERR_BIT] |-> !irq_error)
    else $error("masked error irq raised");

  // completion flags
  AST_TX_SET: assert property (@(posedge pclk) disable iff (!presetn)
    tx_resp_done |=> tx_response_done_flag)
    else $error("tx flag not set");
  AST_RX_SET: assert property (@(posedge pclk) disable iff (!presetn)
    rx_resp_done |=> rx_response_done_flag)
    else $error("rx flag not set");
  AST_ID_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (ident_rx_done || header_tx_done) |=> ident_done_flag)
    else $error("id flag not set");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (ident_done_flag && !clr_id) |=> ident_done_flag)
    else $error("id flag lost");
  AST_TX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_response_done_flag && !clr_tx) |=> tx_response_done_flag)
    else $error("tx flag lost");
  AST_RX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_response_done_flag && !clr_rx) |=> rx_response_done_flag)
    else $error("rx flag lost");
  AST_RX_UART: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_uart_rd ##0 !rx_resp_done) |=> !rx_response_done_flag)
    else $error("rx not cleared");
  AST_TX_UART: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_uart_wr ##0 !tx_resp_done) |=> !tx_response_done_flag)
    else $error("tx not cleared");
  AST_COMM_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    !(ident_done_flag || tx_response_done_flag || rx_response_done_flag) |-> !irq_comm)
    else $error("comm irq without flag");
  AST_COMM_RX: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_response_done_flag && irq_en_reg[lsi_pkg::RX_BIT]) |-> irq_comm)
    else $error("rx irq missing");

  // status, enables and bit timing
  AST_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && (paddr == lsi_pkg::STATUS_ADDR)) |-> (prdata[4] == (rx_active || tx_active)))
    else $error("busy wrong");
  AST_EN_RSV: assert property (@(posedge pclk) disable iff (!presetn)
    en_wr |=> (irq_en_reg[7:4] == 4'h0))
    else $error("reserved enable bits set");
  AST_RESYNC: assert property (@(posedge pclk) disable iff (!presetn)
    seq_btr_write |=> (resync_enable == !$past(pwdata[lsi_pkg::RESYNC_BIT])))
    else $error("resync control wrong");
  AST_BT_FIELD: assert property (@(posedge pclk) disable iff (!presetn)
    seq_btr_write |=> (bit_timing_field == $past(pwdata[5:0])))
    else $error("bit timing field wrong");
  AST_CLASSIC: assert property (@(posedge pclk) disable iff (!presetn)
    classic_only |-> (ident_status_code[2:1] == 2'h2))
    else $error("classic checksum on wrong id");
  AST_ID_PLAIN: assert property (@(posedge pclk) disable iff (!presetn)
    (ident_in < lsi_pkg::ID_RSV_BASE) |-> !ident_status_code[2])
    else $error("ordinary id flagged");
  AST_ID_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    (ident_in >= lsi_pkg::ID_RSV_BASE) |-> (ident_status_code[1:0] == ident_in[1:0]))
    else $error("reserved id code wrong");
endmodule
`default_nettype wire

// *** tb/lsi_far_node.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsi_far_node (
  input  wire logic  pclk,
  output logic       rx_active,
  output logic       tx_active,
  output logic [5:0] ident_in,
  output logic       ident_rx_done,
  output logic       header_tx_done,
  output logic       tx_resp_done,
  output logic       rx_resp_done,
  output logic [7:0] err_event,
  output logic [7:0] rx_data_in
);
  initial begin
    {rx_active, tx_active, ident_in, ident_rx_done, header_tx_done} = 10'h0;
    {tx_resp_done, rx_resp_done, err_event, rx_data_in} = 18'h0;
  end
  task automatic line(input logic rx, input logic tx);
    @(posedge pclk);
    rx_active <= rx;
    tx_active <= tx;
  endtask
  // header seen or sent, then response after gap cycles
  task automatic frame(input logic [5:0] id, input logic master, input logic tx, input int gap);
    @(posedge pclk);
    ident_in <= id;
    ident_rx_done <= !master;
    header_tx_done <= master;
    @(posedge pclk);
    {ident_rx_done, header_tx_done} <= 2'h0;
    repeat (gap) @(posedge pclk);
    tx_resp_done <= tx;
    rx_resp_done <= !tx;
    rx_data_in <= {id, 2'h1};
    @(posedge pclk);
    {tx_resp_done, rx_resp_done} <= 2'h0;
  endtask
  task automatic fault(input logic [7:0] e);
    @(posedge pclk);
    err_event <= e;
    @(posedge pclk);
    err_event <= 8'h00;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_lsi_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_lsi_top;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [11:0] A_ST = lsi_pkg::STATUS_ADDR;
  localparam logic [11:0] A_EN = lsi_pkg::IRQEN_ADDR;
  localparam logic [11:0] A_ER = lsi_pkg::ERRFLAG_ADDR;
  localparam logic [11:0] A_BT = lsi_pkg::BITTIME_ADDR;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, s_err;
  logic        rx_active, tx_active, ident_rx_done, header_tx_done, tx_resp_done;
  logic        rx_resp_done, tx_data_load, uart_mode, classic_only, resync_enable;
  logic        irq_comm, irq_error;
  logic [5:0]  ident_in, bit_timing_field;
  logic [7:0]  err_event, rx_data_in, tx_data_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s_rdata, r;
  int          fails, tests_run;
  lsi_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_active, .tx_active, .ident_in, .ident_rx_done, .header_tx_done,
    .tx_resp_done, .rx_resp_done, .err_event, .rx_data_in, .tx_data_out, .tx_data_load,
    .uart_mode, .classic_only, .resync_enable, .bit_timing_field, .irq_comm, .irq_error);
  lsi_far_node u_far (.pclk, .rx_active, .tx_active, .ident_in, .ident_rx_done,
    .header_tx_done, .tx_resp_done, .rx_resp_done, .err_event, .rx_data_in);
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    s_rdata <= prdata;
    s_err <= pslverr;
  end
  task automatic stop_test;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
    r = s_rdata;
    if (n >= 20) fails++;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask
  task automatic t_reset;
    rd(A_ST, ALL, 32'h0);
    rd(A_EN, ALL, 32'h0);
    rd(A_ER, ALL, 32'h0);
    rd(A_BT, ALL, 32'h20);
    chk(resync_enable, 32'h1);
  endtask
  task automatic t_ident;
    logic [5:0] ids [6] = '{6'h11, 6'h3B, 6'h3C, 6'h3D, 6'h3E, 6'h3F};
    logic       rs;
    logic [31:0] m, x;
    foreach (ids[i]) begin
      rs = ids[i][5:2] == 4'hF;
      m = {24'h0, 1'b1, {2{rs}}, 5'h1F};
      x = {24'h0, rs, ids[i][1:0] & {2{rs}}, 5'h05};
      u_far.frame(ids[i], 1'b0, 1'b0, i);
      rd(A_ST, m, x);
      chk(classic_only, ids[i] == 6'h3C || ids[i] == 6'h3D);
      apb(1'b1, A_ST, 32'h0F);
    end
  endtask
  task automatic t_busy;
    u_far.line(1'b1, 1'b0);
    rd(A_ST, 32'h10, 32'h10);
    u_far.line(1'b0, 1'b1);
    rd(A_ST, 32'h10, 32'h10);
    u_far.line(1'b0, 1'b0);
    rd(A_ST, 32'h10, 32'h0);
  endtask
  task automatic t_flags;
    apb(1'b1, A_EN, 32'h04);
    u_far.frame(6'h20, 1'b1, 1'b1, 3);
    rd(A_ST, 32'h1F, 32'h06);
    chk({irq_comm, irq_error}, 32'h2);
    apb(1'b1, A_ST, 32'h00);
    rd(A_ST, 32'h1F, 32'h06);
    apb(1'b1, A_ST, 32'h04);
    chk(irq_comm, 32'h0);
    apb(1'b1, A_EN, 32'h02);
    chk(irq_comm, 32'h1);
    apb(1'b1, A_ST, 32'h02);
    chk(irq_comm, 32'h0);
    apb(1'b1, A_EN, 32'h01);
    u_far.frame(6'h21, 1'b0, 1'b0, 0);
    @(negedge pclk);
    chk(irq_comm, 32'h1);
    apb(1'b1, A_ST, 32'h05);
    rd(A_ST, 32'h0F, 32'h0);
  endtask
  task automatic t_err;
    logic [7:0] acc;
    acc = 8'h00;
    apb(1'b1, A_EN, 32'h08);
    for (int i = 0; i < 8; i++) begin
      u_far.fault(8'h01 << i);
      acc |= 8'h01 << i;
      rd(A_ER, ALL, acc);
      rd(A_ST, 32'h08, 32'h08);
      chk(irq_error, 32'h1);
    end
    apb(1'b1, A_EN, 32'h00);
    chk(irq_error, 32'h0);
    apb(1'b1, A_ST, 32'h08);
    rd(A_ER, ALL, 32'h0);
    rd(A_ST, 32'h08, 32'h0);
  endtask
  task automatic t_uart;
    apb(1'b1, lsi_pkg::CTRL_ADDR, 32'h01);
    chk(uart_mode, 32'h1);
    u_far.frame(6'h15, 1'b0, 1'b0, 1);
    u_far.fault(8'h04);
    rd(lsi_pkg::DATA_ADDR, ALL, 32'h55);
    rd(A_ST, 32'h0F, 32'h04);
    u_far.frame(6'h16, 1'b1, 1'b1, 0);
    apb(1'b1, lsi_pkg::DATA_ADDR, 32'hC3);
    chk(tx_data_out, 32'hC3);
    chk(tx_data_load, 32'h1);
    rd(A_ST, 32'h02, 32'h0);
    apb(1'b1, lsi_pkg::CTRL_ADDR, 32'h00);
  endtask
  task automatic t_misc;
    apb(1'b0, 12'h3FC, 32'h0);
    chk(s_err, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, A_BT, 32'hD5);
    rd(A_BT, ALL, 32'h95);
    chk({resync_enable, bit_timing_field}, 32'h15);
    apb(1'b1, A_EN, 32'h0F);
    rd(A_EN, ALL, 32'h0F);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 49'h0;
    fails = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ident;
    t_busy;
    t_flags;
    t_err;
    t_uart;
    t_misc;
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
